// >>> hw/utc_codec.v
// Command/status byte layer of the transceiver side of the link bus.
// Assumes the bus clock LINK_CLK and all line inputs are asynchronous to
// CLOCK; they pass two flip-flops and LINK_CLK edges are found by sampling.
`timescale 1ns/10ps
`include "utc_map.vh"
module utc_codec (
  // Clock and reset
  input  wire       CLOCK,
  input  wire       RST_B,
  // Link bus
  input  wire       LINK_CLK,
  input  wire [7:0] DATA_IN,
  output reg  [7:0] DATA_OUT,
  output wire [7:0] DATA_OE_B,
  input  wire       STP,
  output reg        DIR,
  output reg        NXT,
  // Line and analog status
  input  wire       DP_LINE,
  input  wire       DM_LINE,
  input  wire       SQUELCH,
  input  wire       HS_DIFF_OUT,
  input  wire       SESS_END,
  input  wire       SESS_VLD,
  input  wire       A_VBUS_VLD,
  input  wire       B_VALID,
  input  wire       ID_PIN,
  input  wire       RX_ACTIVE,
  input  wire       RX_ERROR,
  input  wire       HOST_DISC,
  // Configuration
  input  wire [1:0] XCVR_SELECT,
  input  wire       TERM_SELECT,
  input  wire       BVALID_RISE_EN,
  input  wire       BVALID_FALL_EN,
  input  wire       STATUS_QUIET,
  // Decoded command results
  output reg        TX_START,
  output reg        TX_NOPID,
  output reg  [3:0] TX_PID,
  output reg        REG_WRITE,
  output reg        REG_READ,
  output reg        REG_EXT,
  output reg  [7:0] REG_ADDR,
  output reg  [7:0] REG_WDATA,
  output reg        REG_STB,
  output reg  [7:0] TX_DATA,
  output reg        TX_DATA_STB,
  output reg        TX_END
);
  localparam S_IDLE = 5'b00001;
  localparam S_ADDR = 5'b00010;
  localparam S_WDAT = 5'b00100;
  localparam S_TX   = 5'b01000;
  localparam S_STAT = 5'b10000;

  // Two-flop synchronisers for every asynchronous input
  wire [21:0] raw_in = {LINK_CLK, DATA_IN, STP, DP_LINE, DM_LINE, SQUELCH,
                        HS_DIFF_OUT, SESS_END, SESS_VLD, A_VBUS_VLD,
                        B_VALID, ID_PIN, RX_ACTIVE, RX_ERROR, HOST_DISC};
  reg  [21:0] sync1;
  reg  [21:0] sync2;
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      sync1 <= 22'h000000;
      sync2 <= 22'h000000;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end
  wire       lclk  = sync2[21];
  wire [7:0] data  = sync2[20:13];
  wire       stp   = sync2[12];
  wire       dp    = sync2[11];
  wire       dm    = sync2[10];
  wire       squel = sync2[9];
  wire       hsd   = sync2[8];
  wire       s_end = sync2[7];
  wire       s_vld = sync2[6];
  wire       a_vld = sync2[5];
  wire       bval  = sync2[4];
  wire       id_l  = sync2[3];
  wire       rxa   = sync2[2];
  wire       rxe   = sync2[1];
  wire       hdis  = sync2[0];

  reg  lclk_d;
  reg  bval_d;
  wire lrise = lclk && !lclk_d;
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      lclk_d <= 1'b0;
      bval_d <= 1'b0;
    end else begin
      lclk_d <= lclk;
      bval_d <= bval;
    end
  end

  // Line state encoding by speed mode
  reg [1:0] line_state;
  always @* begin
    if (XCVR_SELECT == 2'b00 && !TERM_SELECT)
      line_state = squel ? `UTC_LS_SE0 : 2'b01;
    else if (XCVR_SELECT == 2'b00)
      line_state = squel ? 2'b00 : (hsd ? 2'b01 : 2'b10);
    else
      line_state = {dm, dp};
  end

  reg [1:0] vbus_state;
  always @* begin
    if (a_vld)
      vbus_state = `UTC_VB_AVLD;
    else if (s_vld)
      vbus_state = `UTC_VB_SESS;
    else if (!s_end)
      vbus_state = `UTC_VB_LOW;
    else
      vbus_state = `UTC_VB_END;
  end

  reg [1:0] rx_event;
  always @* begin
    if (hdis)
      rx_event = `UTC_EV_DISC;
    else if (rxa && rxe)
      rx_event = `UTC_EV_ERR;
    else if (rxa)
      rx_event = `UTC_EV_ACT;
    else
      rx_event = `UTC_EV_NONE;
  end

  // Status tracking waits until the synchronisers and edge flops hold
  // real pin levels, so no byte reports their reset contents
  reg  [1:0] warm;
  wire       armed = (warm == `UTC_WARM);
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B)
      warm <= 2'b00;
    else if (!armed)
      warm <= warm + 2'b01;
  end

  // Alternate interrupt bit marks an enabled session-valid edge
  wire alternate_interrupt_bit = armed && ((BVALID_RISE_EN && bval && !bval_d) ||
                 (BVALID_FALL_EN && !bval && bval_d));
  wire [6:0] fields = {id_l, rx_event, vbus_state, line_state};
  reg  [6:0] last_fields;
  reg        alt_pend;
  // An edge that met a full queue is kept until it can be queued, but is dropped while STATUS_QUIET is set
  wire       alt_bit = alternate_interrupt_bit || alt_pend;
  wire       change = armed &&
                      ((fields != last_fields) || alt_bit);

  // Status bytes queue here until the bus is free to turn around
  wire       q_ready;
  wire       st_valid;
  reg        st_take;
  wire [7:0] st_byte;
  wire [7:0] new_status = {alt_bit, fields};
  // While quiet no status byte is queued
  wire       q_push = change && !STATUS_QUIET;

  utc_fifo #(
    .WIDTH (8),
    .DEPTH (`UTC_FIFO_DEPTH),
    .AW    (`UTC_FIFO_AW)
  ) u_status_q (
    .clk       (CLOCK),
    .rst_b     (RST_B),
    .in_valid  (q_push),
    .in_ready  (q_ready),
    .in_data   (new_status),
    .out_valid (st_valid),
    .out_ready (st_take),
    .out_data  (st_byte)
  );

  // Fields are only marked reported once queued; a full queue retries
  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      last_fields <= 7'h00;
      alt_pend    <= 1'b0;
    end else begin
      // While quiet the last reported value is kept: a change that is gone
      // again by the exit sends nothing, one that stays is sent then
      if (armed && q_ready && !STATUS_QUIET)
        last_fields <= fields;
      alt_pend <= alt_bit && !q_ready && !STATUS_QUIET;
    end
  end

  reg [4:0] state;
  reg [4:0] next_state;
  reg       tx_run;
  assign DATA_OE_B = DIR ? 8'h00 : 8'hff;

  wire [1:0] code = data[`UTC_CODE_HI:`UTC_CODE_LO];
  wire [5:0] pay  = data[`UTC_PAY_HI:`UTC_PAY_LO];

  always @* begin
    next_state = state;
    st_take    = 1'b0;
    case (state)
      S_IDLE: begin
        if (lrise && data[3:0] == 4'h0 && code == `UTC_CODE_IDLE &&
            st_valid)
          next_state = S_STAT;
        else if (lrise && code == `UTC_CODE_TX)
          next_state = S_TX;
        else if (lrise && code == `UTC_CODE_WR)
          next_state = (pay == `UTC_PAY_EXT) ? S_ADDR : S_WDAT;
        else if (lrise && code == `UTC_CODE_RD && pay == `UTC_PAY_EXT)
          next_state = S_ADDR;
      end
      S_ADDR: begin
        if (lrise)
          next_state = REG_WRITE ? S_WDAT : S_IDLE;
      end
      S_WDAT: begin
        if (lrise)
          next_state = S_IDLE;
      end
      S_TX: begin
        if (lrise && stp)
          next_state = S_IDLE;
      end
      S_STAT: begin
        if (lrise) begin
          st_take = 1'b1;
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state       <= S_IDLE;
      DIR         <= 1'b0;
      NXT         <= 1'b0;
      DATA_OUT    <= `UTC_BUS_IDLE;
      TX_START    <= 1'b0;
      TX_NOPID    <= 1'b0;
      TX_PID      <= 4'h0;
      REG_WRITE   <= 1'b0;
      REG_READ    <= 1'b0;
      REG_EXT     <= 1'b0;
      REG_ADDR    <= 8'h00;
      REG_WDATA   <= 8'h00;
      REG_STB     <= 1'b0;
      TX_DATA     <= 8'h00;
      TX_DATA_STB <= 1'b0;
      TX_END      <= 1'b0;
      tx_run      <= 1'b0;
    end else begin
      state       <= next_state;
      TX_START    <= 1'b0;
      REG_STB     <= 1'b0;
      TX_DATA_STB <= 1'b0;
      TX_END      <= 1'b0;
      if (lrise) begin
        NXT <= 1'b0;
        DIR <= (next_state == S_STAT);
        if (next_state == S_STAT)
          DATA_OUT <= st_byte;
        if (state == S_STAT)
          DATA_OUT <= `UTC_BUS_IDLE;
      end
      if (state == S_IDLE && lrise && data[3:0] != 4'h0 ||
          state == S_IDLE && lrise && code != `UTC_CODE_IDLE) begin
        NXT       <= 1'b1;
        REG_WRITE <= (code == `UTC_CODE_WR);
        REG_READ  <= (code == `UTC_CODE_RD);
        tx_run    <= 1'b0;
        REG_EXT   <= (code[1] && pay == `UTC_PAY_EXT);
        REG_ADDR  <= {2'b00, pay};
        TX_NOPID  <= (code == `UTC_CODE_TX && pay == `UTC_PAY_ZERO);
        TX_PID    <= data[3:0];
        if (code == `UTC_CODE_RD && pay != `UTC_PAY_EXT)
          REG_STB <= 1'b1;
      end
      if (state == S_ADDR && lrise) begin
        REG_ADDR <= data;
        NXT      <= REG_WRITE;
        if (REG_READ)
          REG_STB <= 1'b1;
      end
      if (state == S_WDAT && lrise) begin
        REG_WDATA <= data;
        REG_STB   <= 1'b1;
      end
      if (state == S_TX && lrise) begin
        if (stp) begin
          TX_END <= 1'b1;
        end else begin
          // TX_START only pulses once the first data byte after the command is taken
          if (!tx_run)
            TX_START <= 1'b1;
          tx_run      <= 1'b1;
          TX_DATA     <= data;
          TX_DATA_STB <= 1'b1;
          NXT         <= 1'b1;
        end
      end
    end
  end
endmodule // utc_codec

// >>> common/utc_map.vh
// Constants for the transmit/receive command byte layer of the transceiver.
// Assumes the includer is a module of this block; definitions only.
`ifndef UTC_MAP_VH
`define UTC_MAP_VH
`define UTC_CODE_HI      7
`define UTC_CODE_LO      6
`define UTC_PAY_HI       5
`define UTC_PAY_LO       0
`define UTC_CODE_IDLE    2'b00
`define UTC_CODE_TX      2'b01
`define UTC_CODE_WR      2'b10
`define UTC_CODE_RD      2'b11
`define UTC_PAY_EXT      6'h2f
`define UTC_PAY_ZERO     6'h00
`define UTC_BUS_IDLE     8'h00
`define UTC_LS_SE0       2'b00
`define UTC_LS_J         2'b01
`define UTC_LS_K         2'b10
`define UTC_LS_SE1       2'b11
`define UTC_VB_END       2'b00
`define UTC_VB_LOW       2'b01
`define UTC_VB_SESS      2'b10
`define UTC_VB_AVLD      2'b11
`define UTC_EV_NONE      2'b00
`define UTC_EV_ACT       2'b01
`define UTC_EV_ERR       2'b11
`define UTC_EV_DISC      2'b10
`define UTC_BIT_ID       6
`define UTC_BIT_ALT      7
`define UTC_FIFO_DEPTH   4
`define UTC_FIFO_AW      2
`define UTC_WARM         2'b11
`endif

// >>> hw/utc_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module utc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_b,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg             out_full;
  wire            push;
  wire            pop;
  wire            load;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign push      = in_valid && in_ready;
  // Output register refills whenever empty or being taken
  assign load      = (count != {(AW+1){1'b0}}) && (!out_full || out_ready);
  assign pop       = load;
  assign out_valid = out_full;

  always @(posedge clk) begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr   <= {AW{1'b0}};
      rd_ptr   <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      out_full <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop) begin
        rd_ptr   <= rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
      end
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
      if (load)
        out_full <= 1'b1;
      else if (out_ready)
        out_full <= 1'b0;
    end
  end
endmodule // utc_fifo

// >>> dv/utc_checker.sv
// Checker for the command/status byte layer, bound to utc_codec.
// Assumes one clock domain and link bytes at least 7 clocks apart.
`timescale 1ns/10ps
module utc_checker (
  // Clock and reset
  input logic       CLOCK,
  input logic       RST_B,
  // Bus side
  input logic [7:0] DATA_OUT,
  input logic [7:0] DATA_OE_B,
  input logic       DIR,
  input logic       NXT,
  // Decoded results
  input logic       REG_STB,
  input logic       REG_WRITE,
  input logic       REG_READ,
  input logic       TX_START
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  property p_oe; DATA_OE_B == {8{~DIR}}; endproperty
  a_oe: assert property (p_oe) else $error("bus enable wrong");
  property p_dir_len; $rose(DIR) |-> DIR[*6]; endproperty
  a_dir_len: assert property (p_dir_len) else $error("dir short");
  property p_data; $rose(DIR) |=> $stable(DATA_OUT)[*5]; endproperty
  a_data: assert property (p_data) else $error("status moved");
  property p_nxt_dir; $rose(NXT) |-> !DIR; endproperty
  a_nxt_dir: assert property (p_nxt_dir) else $error("nxt in dir");
  property p_nxt_len; $rose(NXT) |-> NXT[*6]; endproperty
  a_nxt_len: assert property (p_nxt_len) else $error("nxt short");
  property p_stb; REG_STB |=> !REG_STB; endproperty
  a_stb: assert property (p_stb) else $error("strobe long");
  property p_kind; REG_STB |-> REG_WRITE != REG_READ; endproperty
  a_kind: assert property (p_kind) else $error("access kind");
  property p_start; TX_START |=> !TX_START[*4]; endproperty
  a_start: assert property (p_start) else $error("start twice");
endmodule // utc_checker

// >>> dv/utc_link_model.sv
// Link controller model: puts command and data bytes on the bus.
// Assumes a free link clock; bytes change on its falling edge.
`timescale 1ns/10ps
module utc_link (
  // Link bus
  input  wire       link_clk,
  output reg  [7:0] data,
  output reg        stp
);
  initial begin
    data = 8'h00;
    stp  = 1'h0;
  end
  // Fall to fall keeps the byte steady across the sampled rise
  task send(input [7:0] b, input s);
    begin
      @(negedge link_clk);
      data = b;
      stp  = s;
      @(posedge link_clk);
    end
  endtask
endmodule // utc_link

// >>> dv/testbench.sv
// Bench for utc_codec: link model on the bus, status levels from here.
// Assumes full-speed peripheral mode unless a row sets another.
`timescale 1ns/10ps
module testbench;
  logic        clock = 1'h0;
  logic        rst_b = 1'h0;
  logic        lclk  = 1'h0;
  logic [13:0] st    = 14'h1805;
  logic        bv = 1'h0, ren = 1'h0, fen = 1'h0, quiet = 1'h0;
  wire  [7:0]  din, dout, oe_b, addr, wdata, txd;
  wire  [3:0]  pid;
  wire         stp, dir, nxt, start, nopid, wr, rd, ext, stb, dstb, tend;
  logic [7:0]  stb_n = 0, st_n = 0, ds_n = 0, end_n = 0, dir_n = 0;
  logic        dir_q = 1'h0;
  int          bad_count = 0, compares = 0, i;
  logic [7:0]  c, a, d, ad, b, n1, n2, n3;
  logic [2:0]  f;
  // cmd, addr byte, data byte, {wr, rd, ext}, expected address
  logic [34:0] cr [6] = '{
    {8'h85, 8'h00, 8'h3c, 3'h4, 8'h05}, {8'haf, 8'h91, 8'h5a, 3'h5, 8'h91},
    {8'hc7, 8'h00, 8'h00, 3'h2, 8'h07}, {8'hef, 8'ha4, 8'h00, 3'h3, 8'ha4},
    {8'hbe, 8'h00, 8'h77, 3'h4, 8'h3e}, {8'hee, 8'h00, 8'h00, 3'h2, 8'h2e}};
  // Status levels beside the status byte they must produce
  logic [21:0] sr [9] = '{
    {14'h1920, 8'h54}, {14'h186a, 8'h3a}, {14'h199b, 8'h6f},
    {14'h1805, 8'h01}, {14'h0405, 8'h00}, {14'h0005, 8'h01},
    {14'h0805, 8'h02}, {14'h0a05, 8'h01}, {14'h3806, 8'h02}};
  always #12.5 clock = ~clock;
  initial begin
    #7;
    forever #100 lclk = ~lclk;
  end
  utc_codec u_utc_codec (
    .CLOCK(clock), .RST_B(rst_b), .LINK_CLK(lclk), .DATA_IN(din),
    .DATA_OUT(dout), .DATA_OE_B(oe_b), .STP(stp), .DIR(dir), .NXT(nxt),
    .DP_LINE(st[0]), .DM_LINE(st[1]), .SQUELCH(st[10]), .HS_DIFF_OUT(st[9]),
    .SESS_END(st[2]), .SESS_VLD(st[3]), .A_VBUS_VLD(st[4]), .B_VALID(bv),
    .ID_PIN(st[8]), .RX_ACTIVE(st[5]), .RX_ERROR(st[6]), .HOST_DISC(st[7]),
    .XCVR_SELECT(st[13:12]), .TERM_SELECT(st[11]), .BVALID_RISE_EN(ren),
    .BVALID_FALL_EN(fen), .STATUS_QUIET(quiet), .TX_START(start),
    .TX_NOPID(nopid), .TX_PID(pid), .REG_WRITE(wr), .REG_READ(rd),
    .REG_EXT(ext), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_STB(stb),
    .TX_DATA(txd), .TX_DATA_STB(dstb), .TX_END(tend));
  utc_link u_utc_link (.link_clk(lclk), .data(din), .stp(stp));
  // Pulses last one clock, so they are counted rather than sampled
  always @(posedge clock) begin
    dir_q <= dir;
    stb_n <= stb_n + (stb === 1'h1);
    st_n  <= st_n + (start === 1'h1);
    ds_n  <= ds_n + (dstb === 1'h1);
    end_n <= end_n + (tend === 1'h1);
    dir_n <= dir_n + (dir === 1'h1 && dir_q !== 1'h1);
  end
  task chk(input [7:0] got, input [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task hang;
    bad_count++;
    $display("wait ran out at %0t", $time);
    summarize;
  endtask
  task sets(input [13:0] v);
    @(posedge clock);
    #2 st = v;
  endtask
  task wstat;
    int k;
    for (k = 0; dir !== 1'h1; k++) begin
      if (k > 200) hang;
      @(posedge clock);
      #1;
    end
    b = dout;
    for (k = 0; dir !== 1'h0; k++) begin
      if (k > 100) hang;
      @(posedge clock);
      #1;
    end
  endtask
  task tx(input [7:0] cm, input [7:0] d1, input [7:0] d2);
    n1 = st_n;
    n2 = ds_n;
    n3 = end_n;
    u_utc_link.send(cm, 1'h0);
    u_utc_link.send(d1, 1'h0);
    chk(nxt, 1'h1);
    chk(st_n - n1, 8'h00);
    u_utc_link.send(d2, 1'h0);
    u_utc_link.send(8'h00, 1'h1);
    repeat (2) u_utc_link.send(8'h00, 1'h0);
    chk(st_n - n1, 8'h01);
    chk(ds_n - n2, 8'h02);
    chk(txd, d2);
    chk(end_n - n3, 8'h01);
    chk(nopid, cm[3:0] == 4'h0);
    if (cm[3:0] != 4'h0) chk(pid, cm[3:0]);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    #2 rst_b = 1'h1;
    repeat (4) u_utc_link.send(8'h00, 1'h0);
    for (i = 0; i < 6; i++) begin
      {c, a, d, f, ad} = cr[i];
      n1 = stb_n;
      u_utc_link.send(c, 1'h0);
      u_utc_link.send(f[0] ? a : (f[2] ? d : 8'h00), 1'h0);
      chk(nxt, 1'h1);
      if (f[0] && f[2]) u_utc_link.send(d, 1'h0);
      repeat (2) u_utc_link.send(8'h00, 1'h0);
      chk({wr, rd, ext}, f);
      chk(addr, ad);
      if (f[2]) chk(wdata, d);
      chk(stb_n - n1, 8'h01);
      chk(nxt, 1'h0);
    end
    tx(8'h4d, 8'h11, 8'h22);
    tx(8'h40, 8'h55, 8'h66);
    for (i = 0; i < 9; i++) begin
      sets(sr[i][21:8]);
      wstat;
      chk(b, sr[i][7:0]);
    end
    @(posedge clock);
    #2 ren = 1'h1;
    bv = 1'h1;
    wstat;
    chk(b, 8'h82);
    repeat (40) @(posedge clock);
    #2 {ren, fen, bv} = 3'h2;
    wstat;
    chk(b, 8'h82);
    repeat (40) @(posedge clock);
    // A change that is gone again before the quiet exit sends nothing
    #2 quiet = 1'h1;
    n1 = dir_n;
    sets(14'h3805);
    repeat (20) @(posedge clock);
    sets(14'h3806);
    repeat (20) @(posedge clock);
    #2 quiet = 1'h0;
    repeat (40) @(posedge clock);
    #2 chk(dir_n - n1, 8'h00);
    // A change that stays is reported once quiet ends
    quiet = 1'h1;
    sets(14'h3805);
    repeat (64) @(posedge clock);
    #2 chk(dir_n - n1, 8'h00);
    quiet = 1'h0;
    wstat;
    chk(b, 8'h01);
    repeat (40) @(posedge clock);
    // Reset lands while a command is still standing
    u_utc_link.send(8'h85, 1'h0);
    u_utc_link.send(8'h00, 1'h0);
    @(posedge clock);
    #2 chk(nxt, 1'h1);
    rst_b = 1'h0;
    #1 chk({dir, nxt, wr}, 8'h00);
    chk(oe_b, 8'hff);
    chk(addr, 8'h00);
    @(posedge clock);
    #2 rst_b = 1'h1;
    // Let the status byte after reset pass before the next command
    wstat;
    chk(b, 8'h01);
    n1 = stb_n;
    u_utc_link.send(8'h85, 1'h0);
    u_utc_link.send(8'h3c, 1'h0);
    repeat (2) u_utc_link.send(8'h00, 1'h0);
    chk(stb_n - n1, 8'h01);
    chk(wdata, 8'h3c);
    chk(addr, 8'h05);
    summarize;
  end
  initial begin
    #400000;
    hang;
  end
endmodule // testbench
bind utc_codec utc_checker u_utc_checker (
  .CLOCK(CLOCK), .RST_B(RST_B), .DATA_OUT(DATA_OUT), .DATA_OE_B(DATA_OE_B),
  .DIR(DIR), .NXT(NXT), .REG_STB(REG_STB), .REG_WRITE(REG_WRITE),
  .REG_READ(REG_READ), .TX_START(TX_START));
